// ===== verilog/wtw_watchdog.sv
`include "wtw_params.svh"
`default_nettype none
module wtw_watchdog #(
  parameter int TICK_CYCLES = `WTW_TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        spi_select_low_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_data_i,
  input  wire logic        wake_arm_wr_i,
  input  wire logic        wake_arm_val_i,
  input  wire logic [2:0]  sbc_mode_i,
  input  wire logic        dev_mode_i,
  input  wire logic        reset_out_i,
  input  wire logic [1:0]  fail_cfg_i,
  output logic             wd_reset_o,
  output logic             wd_failsafe_o,
  output logic             spi_fail_o,
  output logic [1:0]       failure_count_o,
  output logic             stop_disable_arm_a_o,
  output logic             stop_disable_arm_b_o,
  output logic [2:0]       period_select_o,
  output logic             window_type_select_o,
  output logic [1:0]       wd_state_o
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ========================================================
  // Period decode
  function automatic logic [10:0] per_ms(input logic [2:0] sel);
    unique case (sel)
      3'h0: per_ms = `WTW_P10_MS;
      3'h1: per_ms = `WTW_P20_MS;
      3'h2: per_ms = `WTW_P50_MS;
      3'h3: per_ms = `WTW_P100_MS;
      3'h4: per_ms = `WTW_P200_MS;
      3'h5: per_ms = `WTW_P500_MS;
      default: per_ms = `WTW_P1000_MS;
    endcase
  endfunction

  // Scaled limit: period times num over ten
  function automatic logic [10:0] lim(input logic [10:0] p,
                                      input logic [13:0] num);
    logic [24:0] prod;
    prod = {14'h0000, p} * {11'h000, num};
    lim = 11'(prod / {11'h000, `WTW_DEN});
  endfunction

  // ========================================================
  // State and signals
  wtw_pkg::wtw_st_e   st_ff, nxt_st;
  wtw_pkg::wtw_mode_e mode, mode_prev_ff;
  logic          ro_s1_ff, ro_s2_ff, cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic [TW-1:0] tick_cnt_ff;
  logic [10:0]   ms_ff, per, closed_ms, expire_ms;
  logic          tick, wr_ev, par_ok, trig, normal, off_mode;
  logic          fail, good, start_long, stop_dis, wd_fs_ff;
  logic          ro_wait_ff, stop_dis_ff, win_ff, fs_sel_ff;
  logic [2:0]    per_ff;
  logic [1:0]    fail_max;

  assign mode      = wtw_pkg::wtw_mode_e'(sbc_mode_i);
  assign normal    = (mode == wtw_pkg::MODE_NORMAL);
  assign per       = per_ms(per_ff);
  assign closed_ms = lim(per, `WTW_CLOSED_NUM);
  assign expire_ms = win_ff ? lim(per, `WTW_OPEN_NUM) : per;
  assign tick      = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
  assign wr_ev     = cs_s2_ff & ~cs_s3_ff & cfg_wr_i;
  assign par_ok    = ~^cfg_data_i;
  assign trig      = wr_ev & par_ok;
  assign off_mode  = dev_mode_i | (mode == wtw_pkg::MODE_SLEEP) |
                     (mode == wtw_pkg::MODE_RESTART) |
                     (mode == wtw_pkg::MODE_FAILSAFE);
  assign stop_dis  = (mode == wtw_pkg::MODE_STOP) &&
                     (mode_prev_ff != wtw_pkg::MODE_STOP) &&
                     stop_disable_arm_a_o && stop_disable_arm_b_o;
  assign fail_max  = (fail_cfg_i == `WTW_CFG2) ? `WTW_FAIL_MAX_C2
                                               : `WTW_FAIL_MAX;

  // ========================================================
  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ro_s1_ff <= 1'b0;
      ro_s2_ff <= 1'b0;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      ro_s1_ff <= reset_out_i;
      ro_s2_ff <= ro_s1_ff;
      cs_s1_ff <= spi_select_low_i;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end

  // ========================================================
  // Watchdog sequencing
  always_comb begin
    nxt_st     = st_ff;
    fail       = 1'b0;
    good       = 1'b0;
    start_long = 1'b0;
    if (off_mode) begin
      nxt_st = wtw_pkg::ST_OFF;
    end else if (stop_dis) begin
      nxt_st = wtw_pkg::ST_OFF;
    end else begin
      unique case (st_ff)
        wtw_pkg::ST_OFF: begin
          if (stop_dis_ff && (trig || normal)) begin
            start_long = 1'b1;
          end else if (!stop_dis_ff && !ro_wait_ff && ro_s2_ff &&
                       (normal || mode == wtw_pkg::MODE_INIT)) begin
            start_long = 1'b1;
          end
        end
        wtw_pkg::ST_LONG: begin
          if (trig) begin
            good = 1'b1;
          end else if (tick && ms_ff >= `WTW_LONG_MS - 11'h001) begin
            fail = 1'b1;
          end
        end
        wtw_pkg::ST_RUN: begin
          if (trig) begin
            if (win_ff && ms_ff < closed_ms) begin
              fail = 1'b1;
            end else begin
              good = 1'b1;
            end
          end else if (tick && ms_ff >= expire_ms - 11'h001) begin
            fail = 1'b1;
          end
        end
        default: nxt_st = wtw_pkg::ST_OFF;
      endcase
      if (start_long) nxt_st = wtw_pkg::ST_LONG;
      if (good) nxt_st = wtw_pkg::ST_RUN;
      if (fail) nxt_st = wtw_pkg::ST_OFF;
    end
  end

  // State register and mode history
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff        <= wtw_pkg::ST_OFF;
      mode_prev_ff <= wtw_pkg::MODE_INIT;
    end else begin
      st_ff        <= nxt_st;
      mode_prev_ff <= mode;
    end
  end

  // Millisecond prescaler and window timer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tick_cnt_ff <= '0;
      ms_ff       <= 11'h000;
    end else if (nxt_st != st_ff || good) begin
      tick_cnt_ff <= '0;
      ms_ff       <= 11'h000;
    end else begin
      tick_cnt_ff <= tick ? '0 : tick_cnt_ff + TW'(1);
      if (tick && ms_ff != 11'h7FF) ms_ff <= ms_ff + 11'h001;
    end
  end

  // Disabled-for-stop flag and reset-output wait
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stop_dis_ff <= 1'b0;
      ro_wait_ff  <= 1'b0;
    end else begin
      if (stop_dis) stop_dis_ff <= 1'b1;
      else if (start_long || off_mode) stop_dis_ff <= 1'b0;
      if (fail) ro_wait_ff <= 1'b1;
      else if (!ro_s2_ff) ro_wait_ff <= 1'b0;
    end
  end

  // ========================================================
  // Configuration, taken only in normal mode
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      per_ff    <= `WTW_PER_RST;
      win_ff    <= 1'b0;
      fs_sel_ff <= 1'b0;
    end else if (trig && normal) begin
      per_ff    <= cfg_data_i[`WTW_F_PER_HI:`WTW_F_PER_LO];
      win_ff    <= cfg_data_i[`WTW_F_WIN];
      fs_sel_ff <= cfg_data_i[`WTW_F_FS];
    end
  end

  // Stop-mode disable arm bits
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stop_disable_arm_a_o <= 1'b0;
      stop_disable_arm_b_o <= 1'b0;
    end else if (start_long) begin
      stop_disable_arm_a_o <= 1'b0;
      stop_disable_arm_b_o <= 1'b0;
    end else begin
      if (wake_arm_wr_i && normal) begin
        stop_disable_arm_a_o <= wake_arm_val_i &
                                ~stop_disable_arm_a_o;
        if (stop_disable_arm_b_o) stop_disable_arm_b_o <= 1'b0;
      end
      if (trig && normal && cfg_data_i[`WTW_F_ARMB]) begin
        stop_disable_arm_b_o <= stop_disable_arm_a_o;
      end else if (trig && normal) begin
        stop_disable_arm_b_o <= 1'b0;
      end
    end
  end

  // ========================================================
  // Failure count, set wins over clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      failure_count_o <= 2'h0;
      wd_fs_ff        <= 1'b0;
    end else begin
      if (fail) begin
        if (failure_count_o < fail_max)
          failure_count_o <= failure_count_o + 2'h1;
      end else if (good || stop_dis_ff ||
                   mode == wtw_pkg::MODE_SLEEP ||
                   (mode == wtw_pkg::MODE_FAILSAFE && !wd_fs_ff)) begin
        failure_count_o <= 2'h0;
      end
      if (fail) wd_fs_ff <= fs_sel_ff;
      else if (normal) wd_fs_ff <= 1'b0;
    end
  end

  // Event outputs and status
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wd_reset_o    <= 1'b0;
      wd_failsafe_o <= 1'b0;
      spi_fail_o    <= 1'b0;
      wd_state_o    <= 2'h0;
      period_select_o      <= `WTW_PER_RST;
      window_type_select_o <= 1'b0;
    end else begin
      wd_reset_o    <= fail;
      wd_failsafe_o <= fail & fs_sel_ff;
      spi_fail_o    <= wr_ev & ~par_ok;
      wd_state_o    <= nxt_st;
      period_select_o      <= per_ff;
      window_type_select_o <= win_ff;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_closed_hit;
    st_ff == wtw_pkg::ST_RUN && !off_mode && !stop_dis && trig &&
      win_ff && ms_ff < closed_ms;
  endsequence
  sequence s_expire;
    st_ff == wtw_pkg::ST_RUN && !off_mode && !stop_dis && !trig &&
      tick && ms_ff >= expire_ms - 11'h001;
  endsequence

  closed_window_fail_a: assert property (
    s_closed_hit |=> wd_reset_o && wd_state_o == wtw_pkg::ST_OFF)
    else $error("closed window trigger not failed");
  period_expiry_a: assert property (
    s_expire |=> wd_reset_o ##1 !wd_reset_o)
    else $error("expiry did not give one reset pulse");
  bad_parity_a: assert property (
    wr_ev && !par_ok |=> spi_fail_o && $stable(per_ff) && !wd_reset_o)
    else $error("bad parity command not ignored");
  good_service_a: assert property (
    st_ff == wtw_pkg::ST_RUN && !win_ff && trig && !off_mode &&
      !stop_dis |=> ms_ff == 11'h000 && failure_count_o == 2'h0)
    else $error("service did not restart period");
  long_start_a: assert property (
    start_long |=> st_ff == wtw_pkg::ST_LONG && ms_ff == 11'h000 &&
      !stop_disable_arm_a_o && !stop_disable_arm_b_o)
    else $error("long window not started cleanly");
  fail_sat_a: assert property (
    failure_count_o <= fail_max || $changed(fail_cfg_i))
    else $error("failure count past saturation");
  dev_mode_off_a: assert property (
    dev_mode_i |=> !wd_reset_o && st_ff == wtw_pkg::ST_OFF)
    else $error("watchdog active in development mode");
  arm_b_order_a: assert property (
    trig && normal && !stop_disable_arm_a_o && !start_long
      |=> !stop_disable_arm_b_o)
    else $error("second arm set without first");
  stop_cfg_hold_a: assert property (
    mode == wtw_pkg::MODE_STOP |=> $stable(per_ff) && $stable(win_ff))
    else $error("configuration changed in stop mode");
endmodule // wtw_watchdog
`default_nettype wire

// ===== verilog/wtw_params.svh
`ifndef WTW_PARAMS_SVH
`define WTW_PARAMS_SVH
// ==========================================================
// Timing
`define WTW_CLK_NS      25
`define WTW_TICK_NS     1000000
`define WTW_TICK_CYC    ((`WTW_TICK_NS + `WTW_CLK_NS - 1) / `WTW_CLK_NS)
`define WTW_LONG_MS     11'h0C8
`define WTW_P10_MS      11'h00A
`define WTW_P20_MS      11'h014
`define WTW_P50_MS      11'h032
`define WTW_P100_MS     11'h064
`define WTW_P200_MS     11'h0C8
`define WTW_P500_MS     11'h1F4
`define WTW_P1000_MS    11'h3E8
`define WTW_CLOSED_NUM  14'h0006
`define WTW_OPEN_NUM    14'h000E
`define WTW_DEN         14'h000A
// ==========================================================
// Trigger byte fields
`define WTW_F_ARMB      6
`define WTW_F_WIN       5
`define WTW_F_FS        4
`define WTW_F_PER_HI    2
`define WTW_F_PER_LO    0
// ==========================================================
// Reset values and limits
`define WTW_PER_RST     3'h0
`define WTW_FAIL_MAX    2'h2
`define WTW_FAIL_MAX_C2 2'h1
`define WTW_CFG2        2'h1
`endif

// ===== verilog/wtw_pkg.sv
`default_nettype none
// ==========================================================
// Device modes and watchdog states
package wtw_pkg;
  typedef enum logic [2:0] {
    MODE_INIT     = 3'h0,
    MODE_NORMAL   = 3'h1,
    MODE_STOP     = 3'h2,
    MODE_SLEEP    = 3'h3,
    MODE_RESTART  = 3'h4,
    MODE_FAILSAFE = 3'h5
  } wtw_mode_e;
  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_LONG = 2'h1,
    ST_RUN  = 2'h2
  } wtw_st_e;
endpackage
`default_nettype wire

// ===== verification/wtw_host_model.sv
`default_nettype none
// ==========================================================
// Host side of the trigger link
module wtw_host_model (
  input  wire logic       clk_i,
  output logic            spi_select_low_o,
  output logic            cfg_wr_o,
  output logic [7:0]      cfg_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LINK_NS = 200;
  // Idle link: deselected, no write
  initial begin
    spi_select_low_o = 1'b1;
    cfg_wr_o         = 1'b0;
    cfg_data_o       = 8'h00;
  end
  // One 16-bit frame; checksum even unless spoiled
  task automatic send(input logic [6:0] body, input logic spoil);
    @(negedge clk_i);
    spi_select_low_o = 1'b0;
    cfg_wr_o         = 1'b1;
    cfg_data_o       = {(^body) ^ spoil, body};
    #(16 * LINK_NS);
    @(negedge clk_i);
    spi_select_low_o = 1'b1;
    repeat (5) @(negedge clk_i);
    cfg_wr_o   = 1'b0;
    cfg_data_o = ~cfg_data_o; // Released bus shows inverse
  endtask
endmodule // wtw_host_model
`default_nettype wire

// ===== verification/window_timeout_watchdog_bench.sv
`default_nettype none
// ==========================================================
// Watchdog bench: host model, chip-side stimulus, checks
module window_timeout_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 40;
  localparam int LONG = 200 * TICK;
  logic       clk, resetn, dev, reset_out, wake_wr, wake_val;
  logic       sel_n, cfg_wr, rst_p, fs_p, sf_p, arm_a, arm_b, win;
  logic [2:0] mode, per;
  logic [1:0] fail_cfg, count, state;
  logic [7:0] cfg_data;
  int         bad_count, checks, rst_cnt, fs_cnt, sf_cnt, seed;

  wtw_host_model i_host (.clk_i(clk), .spi_select_low_o(sel_n),
    .cfg_wr_o(cfg_wr), .cfg_data_o(cfg_data));
  wtw_watchdog #(.TICK_CYCLES(TICK)) i_dut (.clk_i(clk),
    .resetn_i(resetn), .spi_select_low_i(sel_n), .cfg_wr_i(cfg_wr),
    .cfg_data_i(cfg_data), .wake_arm_wr_i(wake_wr),
    .wake_arm_val_i(wake_val), .sbc_mode_i(mode), .dev_mode_i(dev),
    .reset_out_i(reset_out), .fail_cfg_i(fail_cfg), .wd_reset_o(rst_p),
    .wd_failsafe_o(fs_p), .spi_fail_o(sf_p), .failure_count_o(count),
    .stop_disable_arm_a_o(arm_a), .stop_disable_arm_b_o(arm_b),
    .period_select_o(per), .window_type_select_o(win),
    .wd_state_o(state));

  // ==========================================================
  // Clock, pulse tallies, watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Count one-cycle pulses away from the launching edge
  always @(negedge clk) begin
    if (rst_p === 1'b1)
      rst_cnt++;
    if (fs_p === 1'b1)
      fs_cnt++;
    if (sf_p === 1'b1)
      sf_cnt++;
  end
  // Cut a hang short
  initial begin
    #2_500_000;
    bad_count++;
    end_of_test();
  end

  // ==========================================================
  // Expectations and helpers
  function automatic int per_ms(input logic [2:0] c);
    int tbl[8] = '{10, 20, 50, 100, 200, 500, 1000, 1000};
    return tbl[c];
  endfunction
  function automatic logic [1:0] sat(input int n, input logic [1:0] cfg);
    logic [1:0] m;
    m = (cfg == 2'h1) ? 2'h1 : 2'h2;
    return (n > m) ? m : 2'(n);
  endfunction
  task automatic chk_val(input string what, input logic [2:0] exp,
                         input logic [2:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_num(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic trig(input logic [6:0] body);
    i_host.send(body, 1'b0);
    cyc(2);
  endtask
  task automatic wake(input logic v);
    @(negedge clk);
    wake_wr  = 1'b1;
    wake_val = v;
    cyc(1);
    wake_wr  = 1'b0;
    cyc(1);
  endtask
  // No reset before lo cycles, one reset by hi
  task automatic expect_fail(input int lo, input int hi);
    int r0;
    r0 = rst_cnt;
    cyc(lo);
    chk_num("early reset", r0, rst_cnt);
    for (int i = lo; i < hi && rst_cnt == r0; i++)
      cyc(1);
    chk_num("reset pulse", r0 + 1, rst_cnt);
  endtask
  // Rest of chip: reset output low, restart, back to normal
  task automatic restart();
    reset_out = 1'b0;
    mode      = 3'h4;
    cyc(4);
    chk_val("state", 3'h0, {1'b0, state});
    reset_out = 1'b1;
    mode      = 3'h1;
    cyc(6);
    chk_val("state", 3'h1, {1'b0, state});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int code, p, j;
    logic [6:0] body;
    resetn    = 1'b0;
    mode      = 3'h0;
    dev       = 1'b0;
    reset_out = 1'b0;
    fail_cfg  = 2'h0;
    wake_wr   = 1'b0;
    wake_val  = 1'b0;
    seed      = $urandom(32'hF8AD);
    cyc(10);
    resetn = 1'b1;
    cyc(1);
    chk_val("period", 3'h0, per);
    chk_val("window", 3'h0, {2'h0, win});
    reset_out = 1'b1;
    cyc(6);
    chk_val("state", 3'h1, {1'b0, state});
    expect_fail(LONG - 10, LONG + 10);
    chk_val("count", 3'h1, {1'b0, count});
    chk_num("failsafe", 0, fs_cnt);
    restart();
    for (int i = 0; i < 4; i++) begin
      body = 7'($urandom_range(15, 0));
      trig(body);
      chk_val("period", body[2:0], per);
      chk_val("state", 3'h2, {1'b0, state});
      chk_val("count", 3'h0, {1'b0, count});
    end
    i_host.send(7'($urandom) & 7'h0F, 1'b1);
    cyc(2);
    chk_num("parity error", 1, sf_cnt);
    chk_val("period", body[2:0], per);
    for (int k = 0; k < 2; k++) begin
      // Configuration straps change only under a mid-run reset
      if (k == 1) begin
        resetn   = 1'b0;
        fail_cfg = 2'h1;
        cyc(3);
        resetn   = 1'b1;
        cyc(6);
        chk_val("state", 3'h1, {1'b0, state});
      end
      code = $urandom_range(2, 0);
      p = per_ms(3'(code)) * TICK;
      trig({4'h0, 3'(code)});
      j = rst_cnt;
      cyc(p - 200);
      trig({4'h0, 3'(code)});
      chk_num("service", j, rst_cnt);
      expect_fail(p - 10, p + 10);
      for (j = 1; j <= 3; j++) begin
        chk_val("count", {1'b0, sat(j, fail_cfg)}, {1'b0, count});
        restart();
        if (j < 3)
          expect_fail(LONG - 10, LONG + 10);
      end
    end
    trig(7'h30);
    chk_val("window", 3'h1, {2'h0, win});
    trig(7'h30);
    chk_num("closed hit", 1, fs_cnt);
    restart();
    trig(7'h30);
    cyc(200);
    trig(7'h30);
    chk_val("state", 3'h2, {1'b0, state});
    chk_num("open hit", 1, fs_cnt);
    expect_fail(14 * TICK - 14, 14 * TICK + 6);
    chk_num("failsafe", 2, fs_cnt);
    restart();
    wake(1'b1);
    chk_val("arm a", 3'h1, {2'h0, arm_a});
    wake(1'b1);
    chk_val("arm a", 3'h0, {2'h0, arm_a});
    wake(1'b1);
    trig(7'h40);
    chk_val("arm b", 3'h1, {2'h0, arm_b});
    wake(1'b1);
    chk_val("arm b", 3'h0, {2'h0, arm_b});
    trig(7'h40);
    chk_val("arm b", 3'h0, {2'h0, arm_b});
    wake(1'b1);
    trig(7'h40);
    mode = 3'h2;
    cyc(4);
    chk_val("state", 3'h0, {1'b0, state});
    chk_val("count", 3'h0, {1'b0, count});
    trig(7'h06);
    chk_val("state", 3'h1, {1'b0, state});
    chk_val("arms", 3'h0, {1'b0, arm_a, arm_b});
    chk_val("period", 3'h0, per);
    mode = 3'h1;
    dev  = 1'b1;
    cyc(4);
    chk_val("state", 3'h0, {1'b0, state});
    j = rst_cnt;
    cyc(LONG + 100);
    chk_num("dev reset", j, rst_cnt);
    end_of_test();
  end
endmodule // window_timeout_watchdog_bench
`default_nettype wire
